// ### include/uihm_consts.svh
// Offsets, field positions, reset values and timing counts of the serial port core.
`ifndef UIHM_CONSTS_SVH
`define UIHM_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UIHM_OFF_DATA     6'h00
`define UIHM_OFF_STATUS   6'h04
`define UIHM_OFF_CTRL     6'h08
`define UIHM_OFF_LINE     6'h0C
`define UIHM_OFF_DIVISOR  6'h10
`define UIHM_OFF_IRQ      6'h14
`define UIHM_OFF_MCTL     6'h18
`define UIHM_OFF_MSTS     6'h1C
`define UIHM_OFF_FLINK    6'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UIHM_CTRL_EN      0
`define UIHM_CTRL_MSIE    3
`define UIHM_CTRL_RXIE    4
`define UIHM_CTRL_TXIE    5
`define UIHM_CTRL_RTIE    6
`define UIHM_CTRL_LBE     7
`define UIHM_LINE_PEN     1
`define UIHM_LINE_EPS     2
`define UIHM_LINE_STP2    3
`define UIHM_LINE_FEN     4

// ----------------------------------------------------------------
// Reset values, sizes and timing counts
// ----------------------------------------------------------------
`define UIHM_CTRL_RST     8'h00
`define UIHM_LINE_RST     8'h10
`define UIHM_DIV_RST      16'h000D
`define UIHM_FLINK_RST    8'h00
`define UIHM_DEPTH        5'h10
`define UIHM_HALF         5'h08
`define UIHM_RT_BITS      6'h20
`define UIHM_SUB_LAST     4'hF
`define UIHM_SUB_MID      4'h7
`define UIHM_SUB_MAN      4'hB
`define UIHM_RESP_OK      2'h0
`define UIHM_RESP_ERR     2'h2

`endif

// ### include/uihm_pkg.sv
// Types shared by the serial port core.
package uihm_pkg;

	// Frame sequencer states for both directions.
	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b000,
		SEQ_START = 3'b001,
		SEQ_DATA  = 3'b010,
		SEQ_PAR   = 3'b011,
		SEQ_STOP  = 3'b100
	} uihm_seq_t;

	// One receive buffer entry.
	typedef struct packed {
		logic       brk;
		logic       par;
		logic       frm;
		logic [7:0] data;
	} uihm_rxent_t;

	// Frame link control word, bit 7 down to bit 0.
	typedef struct packed {
		logic rxClockMode;
		logic txClockMode;
		logic clockMasterSelect;
		logic rxManchesterSelect;
		logic txManchesterSelect;
		logic syncSelect;
		logic frameRxEnable;
		logic frameTxEnable;
	} uihm_flink_t;

endpackage : uihm_pkg

// ### src/uihm_core.sv
// Serial port core with buffers, interrupts, modem lines and frame link line modes.
`timescale 1ns/1ps
module uihm_core
	import uihm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [5:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [5:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        serialRxIn,
	output logic             serialTxOut,
	input  wire logic        bitClkIn,
	output logic             bitClkOut,
	input  wire logic        clearToSendN,
	input  wire logic        carrierDetectN,
	input  wire logic        dataSetReadyN,
	input  wire logic        phoneBellDetect,
	output logic             requestToSendN,
	output logic             terminalReadyN,
	output logic             modemStatusIrq,
	output logic             rxFifoIrq,
	output logic             rxTimeoutIrq,
	output logic             txFifoIrq,
	output logic             combinedIrq
);
`include "uihm_consts.svh"

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [5:0]  syncA_reg, syncB_reg, awAddr_reg;
	logic        extPrev_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [31:0] wData_reg, rdata_reg;
	logic [3:0]  wStrb_reg, freeSub_reg, txSub_reg, rxSub_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [7:0]  ctrl_reg, line_reg, flink_reg, txShift_reg, rxShift_reg;
	logic [15:0] div_reg, divCnt_reg;
	logic        request_to_send_n_reg, terminal_ready_n_reg, overrun_reg, msRaw_reg, txPar_reg, txStop_reg;
	logic [2:0]  msPrev_reg, txBit_reg, rxBit_reg;
	logic [7:0]  txMem [16];
	logic [10:0] rxMem [16];
	logic [3:0]  txWp_reg, txRp_reg, rxWp_reg, rxRp_reg;
	logic [4:0]  txCnt_reg, rxCnt_reg;
	logic [5:0]  rtCnt_reg;
	uihm_seq_t   txSt_reg, rxSt_reg;
	logic        rxPar_reg, rxPush_reg, serialTxOut_reg, bitClkOut_reg;
	uihm_rxent_t rxEnt_reg;
	logic [4:0]  irqOut_reg;
	uihm_flink_t fl;
	logic        wrDo, rdTake, rdPop, baud16, bitTick, extRise, extFall, portEn, fifoEn;
	logic        txPush, txPop, txSync, rxSync, txStep, rxTick, rxLine, txCur, lineNext;
	logic [4:0]  cap;
	logic [3:0]  irqRaw, irqMasked;
	logic [31:0] rdWord;

	// Address decode, shared by the read and the write path.
	function automatic logic mapped(input logic [5:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `UIHM_OFF_FLINK);
	endfunction : mapped

	assign fl     = uihm_flink_t'(flink_reg);
	assign portEn = ctrl_reg[`UIHM_CTRL_EN];
	assign fifoEn = line_reg[`UIHM_LINE_FEN];
	assign cap    = fifoEn ? `UIHM_DEPTH : 5'h01; // Depth one fakes a holding register.
	assign txSync = fl.syncSelect && fl.frameTxEnable;
	assign rxSync = fl.syncSelect && fl.frameRxEnable;

	// ----------------------------------------------------------------
	// Pin synchronisers and clock enables
	// ----------------------------------------------------------------
	// Two flops per pin: {bit clock, ring, ready, carrier, send, data}.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_reg   <= 6'h1F;
			syncB_reg   <= 6'h1F;
			extPrev_reg <= 1'b0; // Bit clock rests low, so reset makes no false edge.
		end else begin
			syncA_reg   <= {bitClkIn, phoneBellDetect, dataSetReadyN, carrierDetectN,
				clearToSendN, serialRxIn};
			syncB_reg   <= syncA_reg;
			extPrev_reg <= syncB_reg[5];
		end
	end
	assign extRise = syncB_reg[5] && !extPrev_reg;
	assign extFall = !syncB_reg[5] && extPrev_reg;

	// Divisor down counter gives the sixteen-per-bit enable.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_reg  <= 16'h0000;
			freeSub_reg <= 4'h0;
		end else begin
			divCnt_reg <= baud16 ? div_reg : divCnt_reg - 16'h0001;
			if (baud16) begin
				freeSub_reg <= freeSub_reg + 4'h1;
			end
		end
	end
	assign baud16  = (divCnt_reg == 16'h0000);
	assign bitTick = baud16 && (freeSub_reg == `UIHM_SUB_LAST);

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	assign wrDo   = !awready_reg && !wready_reg && !bvalid_reg;
	assign rdTake = arvalid && arready_reg;
	assign rdPop  = rdTake && (araddr == `UIHM_OFF_DATA) && (rxCnt_reg != 5'h00);
	assign txPush = wrDo && wStrb_reg[0] && (awAddr_reg == `UIHM_OFF_DATA) && (txCnt_reg < cap);

	// Address and data are caught in either order; the answer follows both.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `UIHM_RESP_OK;
			awAddr_reg  <= 6'h00;
			wData_reg   <= 32'h00000000;
			wStrb_reg   <= 4'h0;
		end else begin
			if (awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				awAddr_reg  <= awaddr;
			end
			if (wvalid && wready_reg) begin
				wready_reg <= 1'b0;
				wData_reg  <= wdata;
				wStrb_reg  <= wstrb;
			end
			if (wrDo) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= mapped(awAddr_reg) ? `UIHM_RESP_OK : `UIHM_RESP_ERR;
			end else if (bvalid_reg && bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Read mux; reserved bits read as zero.
	always_comb begin
		rdWord = 32'h00000000;
		case (araddr)
			`UIHM_OFF_DATA:    rdWord[10:0] = rxMem[rxRp_reg];
			`UIHM_OFF_STATUS:  rdWord[13:0] = {txCnt_reg, rxCnt_reg,
				(txSt_reg != SEQ_IDLE) || (txCnt_reg != 5'h00), overrun_reg,
				txCnt_reg >= cap, rxCnt_reg == 5'h00};
			`UIHM_OFF_CTRL:    rdWord[7:0]  = ctrl_reg;
			`UIHM_OFF_LINE:    rdWord[7:0]  = line_reg;
			`UIHM_OFF_DIVISOR: rdWord[15:0] = div_reg;
			`UIHM_OFF_IRQ:     rdWord[3:0]  = irqRaw;
			`UIHM_OFF_MCTL:    rdWord[1:0]  = {!terminal_ready_n_reg, !request_to_send_n_reg};
			`UIHM_OFF_MSTS:    rdWord[3:0]  = syncB_reg[4:1];
			`UIHM_OFF_FLINK:   rdWord[7:0]  = flink_reg;
			default:           rdWord       = 32'h00000000;
		endcase
	end

	// Read channel; a read of the data word pops the receive buffer.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= `UIHM_RESP_OK;
		end else if (rdTake) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rdWord;
			rresp_reg   <= mapped(araddr) ? `UIHM_RESP_OK : `UIHM_RESP_ERR;
		end else if (rvalid_reg && rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Configuration registers; only the low two byte lanes carry fields.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg  <= `UIHM_CTRL_RST;
			line_reg  <= `UIHM_LINE_RST;
			div_reg   <= `UIHM_DIV_RST;
			flink_reg <= `UIHM_FLINK_RST;
			request_to_send_n_reg  <= 1'b1;
			terminal_ready_n_reg  <= 1'b1;
		end else if (wrDo && wStrb_reg[0]) begin
			case (awAddr_reg)
				`UIHM_OFF_CTRL:    ctrl_reg      <= wData_reg[7:0];
				`UIHM_OFF_LINE:    line_reg      <= wData_reg[7:0];
				`UIHM_OFF_DIVISOR: div_reg[7:0]  <= wData_reg[7:0];
				`UIHM_OFF_FLINK:   flink_reg     <= wData_reg[7:0];
				`UIHM_OFF_MCTL: begin
					request_to_send_n_reg <= !wData_reg[0];
					terminal_ready_n_reg <= !wData_reg[1];
				end
				default: ;
			endcase
			if (wStrb_reg[1] && awAddr_reg == `UIHM_OFF_DIVISOR) begin
				div_reg[15:8] <= wData_reg[15:8];
			end
		end else if (wrDo && wStrb_reg[1] && awAddr_reg == `UIHM_OFF_DIVISOR) begin
			div_reg[15:8] <= wData_reg[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	// Transmit buffer; writes beyond the current capacity are dropped.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txWp_reg  <= 4'h0;
			txRp_reg  <= 4'h0;
			txCnt_reg <= 5'h00;
		end else begin
			if (txPush) begin
				txWp_reg <= txWp_reg + 4'h1;
			end
			if (txPop) begin
				txRp_reg <= txRp_reg + 4'h1;
			end
			txCnt_reg <= txCnt_reg + {4'h0, txPush} - {4'h0, txPop};
		end
	end

	// Storage arrays have no reset, so reset can never act as a write enable.
	always_ff @(posedge sys_clk) begin
		if (txPush) begin
			txMem[txWp_reg] <= wData_reg[7:0];
		end
		if (rxPush_reg && rxCnt_reg < cap) begin
			rxMem[rxWp_reg] <= rxEnt_reg;
		end
	end

	// Receive buffer; a full buffer drops the new character and flags overrun.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxWp_reg    <= 4'h0;
			rxRp_reg    <= 4'h0;
			rxCnt_reg   <= 5'h00;
			overrun_reg <= 1'b0;
		end else begin
			if (rxPush_reg && rxCnt_reg < cap) begin
				rxWp_reg <= rxWp_reg + 4'h1;
			end
			if (rdPop) begin
				rxRp_reg <= rxRp_reg + 4'h1;
			end
			rxCnt_reg <= rxCnt_reg + {4'h0, rxPush_reg && rxCnt_reg < cap} - {4'h0, rdPop};
			// Set beats a clear in the same cycle.
			if (rxPush_reg && rxCnt_reg >= cap) begin
				overrun_reg <= 1'b1;
			end else if (wrDo && awAddr_reg == `UIHM_OFF_STATUS) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// An external transmit clock moves data on its falling edge, ahead of the rise.
	assign txStep = (txSync && fl.txClockMode && !fl.clockMasterSelect) ? extFall
		: (baud16 && txSub_reg == `UIHM_SUB_LAST);
	assign txPop  = (txSt_reg == SEQ_IDLE) && portEn && (txCnt_reg != 5'h00);

	always_comb begin
		case (txSt_reg)
			SEQ_START: txCur = 1'b0;
			SEQ_DATA:  txCur = txShift_reg[0];
			SEQ_PAR:   txCur = txPar_reg;
			default:   txCur = 1'b1;
		endcase
		lineNext = txCur;
		if (txSync && fl.txManchesterSelect && txSt_reg != SEQ_IDLE) begin
			lineNext = txSub_reg[3] ? txCur : !txCur;
		end
	end

	// Character sequencer, with framing skipped in synchronous mode.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txSt_reg    <= SEQ_IDLE;
			txShift_reg <= 8'h00;
			txBit_reg   <= 3'h0;
			txSub_reg   <= 4'h0;
			txPar_reg   <= 1'b0;
			txStop_reg  <= 1'b0;
		end else if (txPop) begin
			txShift_reg <= txMem[txRp_reg];
			txPar_reg   <= line_reg[`UIHM_LINE_EPS] ? ^txMem[txRp_reg] : ~^txMem[txRp_reg];
			txSt_reg    <= txSync ? SEQ_DATA : SEQ_START;
			txBit_reg   <= 3'h0;
			txSub_reg   <= 4'h0;
			txStop_reg  <= 1'b0;
		end else if (txSt_reg != SEQ_IDLE) begin
			if (baud16) begin
				txSub_reg <= txSub_reg + 4'h1;
			end
			if (txStep) begin
				txSub_reg <= 4'h0;
				case (txSt_reg)
					SEQ_START: txSt_reg <= SEQ_DATA;
					SEQ_DATA: begin
						txShift_reg <= {1'b0, txShift_reg[7:1]};
						txBit_reg   <= txBit_reg + 3'h1;
						if (txBit_reg == 3'h7) begin
							txSt_reg <= txSync ? SEQ_IDLE
								: (line_reg[`UIHM_LINE_PEN] ? SEQ_PAR : SEQ_STOP);
						end
					end
					SEQ_PAR: txSt_reg <= SEQ_STOP;
					SEQ_STOP: begin
						txStop_reg <= 1'b1;
						if (!line_reg[`UIHM_LINE_STP2] || txStop_reg) begin
							txSt_reg <= SEQ_IDLE;
						end
					end
					default: txSt_reg <= SEQ_IDLE;
				endcase
			end
		end
	end

	// Line and internal bit clock; the clock rises mid-bit, data is settled by then.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			serialTxOut_reg <= 1'b1;
			bitClkOut_reg   <= 1'b0;
		end else begin
			serialTxOut_reg <= lineNext;
			bitClkOut_reg   <= txSync && fl.txClockMode && fl.clockMasterSelect
				&& txSt_reg != SEQ_IDLE && txSub_reg[3];
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	assign rxLine = ctrl_reg[`UIHM_CTRL_LBE] ? serialTxOut_reg : syncB_reg[0];
	// Synchronous sample point: external rise, own clock rise, or the free counter at mid-bit (sub 11 when Manchester).
	assign rxTick = (fl.rxClockMode && !fl.clockMasterSelect) ? extRise
		: (fl.rxClockMode && fl.clockMasterSelect) ?
			(baud16 && txSub_reg == `UIHM_SUB_MID && txSt_reg != SEQ_IDLE)
		: (baud16 && freeSub_reg == (fl.rxManchesterSelect ? `UIHM_SUB_MAN
			: `UIHM_SUB_MID));

	// Receive sequencer; start bit checked mid-bit, then one sample per bit.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxSt_reg    <= SEQ_IDLE;
			rxShift_reg <= 8'h00;
			rxBit_reg   <= 3'h0;
			rxSub_reg   <= 4'h0;
			rxPar_reg   <= 1'b0;
			rxPush_reg  <= 1'b0;
			rxEnt_reg   <= '0;
		end else begin
			rxPush_reg <= 1'b0;
			if (!portEn) begin
				rxSt_reg <= SEQ_IDLE;
			end else if (rxSync) begin
				if (rxTick) begin
					rxShift_reg <= {rxLine, rxShift_reg[7:1]};
					rxBit_reg   <= rxBit_reg + 3'h1;
					if (rxBit_reg == 3'h7) begin
						rxPush_reg <= 1'b1;
						rxEnt_reg  <= {3'h0, rxLine, rxShift_reg[7:1]};
					end
				end
			end else if (rxSt_reg == SEQ_IDLE) begin
				rxSub_reg <= 4'h0;
				rxBit_reg <= 3'h0;
				if (!rxLine) begin
					rxSt_reg <= SEQ_START;
				end
			end else if (baud16) begin
				rxSub_reg <= rxSub_reg + 4'h1;
				case (rxSt_reg)
					SEQ_START: if (rxSub_reg == `UIHM_SUB_MID) begin
						rxSub_reg <= 4'h0;
						rxSt_reg  <= rxLine ? SEQ_IDLE : SEQ_DATA;
					end
					SEQ_DATA: if (rxSub_reg == `UIHM_SUB_LAST) begin
						rxShift_reg <= {rxLine, rxShift_reg[7:1]};
						rxBit_reg   <= rxBit_reg + 3'h1;
						rxPar_reg   <= 1'b0;
						if (rxBit_reg == 3'h7) begin
							rxSt_reg <= line_reg[`UIHM_LINE_PEN] ? SEQ_PAR : SEQ_STOP;
						end
					end
					SEQ_PAR: if (rxSub_reg == `UIHM_SUB_LAST) begin
						rxPar_reg <= rxLine;
						rxSt_reg  <= SEQ_STOP;
					end
					SEQ_STOP: if (rxSub_reg == `UIHM_SUB_LAST) begin
						rxPush_reg    <= 1'b1;
						rxEnt_reg.data <= rxShift_reg;
						rxEnt_reg.frm <= !rxLine;
						rxEnt_reg.par <= line_reg[`UIHM_LINE_PEN] && (rxPar_reg !=
							(line_reg[`UIHM_LINE_EPS] ? ^rxShift_reg : ~^rxShift_reg));
						rxEnt_reg.brk <= !rxLine && !rxPar_reg && rxShift_reg == 8'h00;
						rxSt_reg      <= SEQ_IDLE;
					end
					default: rxSt_reg <= SEQ_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt sources
	// ----------------------------------------------------------------
	// Idle bit counter restarts on each arrival and stops once it reaches the limit.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rtCnt_reg <= 6'h00;
		end else if (rxCnt_reg == 5'h00 || rxPush_reg) begin
			rtCnt_reg <= 6'h00;
		end else if (bitTick && rtCnt_reg != `UIHM_RT_BITS) begin
			rtCnt_reg <= rtCnt_reg + 6'h01;
		end
	end

	// Modem change flag; a change in the clearing cycle still wins.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			msPrev_reg <= 3'h7;
			msRaw_reg  <= 1'b0;
		end else begin
			msPrev_reg <= syncB_reg[3:1];
			if (msPrev_reg != syncB_reg[3:1]) begin
				msRaw_reg <= 1'b1;
			end else if (wrDo && awAddr_reg == `UIHM_OFF_IRQ) begin
				msRaw_reg <= 1'b0;
			end
		end
	end

	// Raw order is {timeout, transmit, receive, modem}; transmit ignores port enable.
	assign irqRaw[0] = msRaw_reg;
	assign irqRaw[1] = fifoEn ? (rxCnt_reg >= `UIHM_HALF) : (rxCnt_reg != 5'h00);
	assign irqRaw[2] = fifoEn ? (txCnt_reg <= `UIHM_HALF) : (txCnt_reg == 5'h00);
	assign irqRaw[3] = (rtCnt_reg == `UIHM_RT_BITS) && (rxCnt_reg != 5'h00);
	assign irqMasked = irqRaw & {ctrl_reg[`UIHM_CTRL_RTIE], ctrl_reg[`UIHM_CTRL_TXIE],
		ctrl_reg[`UIHM_CTRL_RXIE], ctrl_reg[`UIHM_CTRL_MSIE]};

	// Registered interrupt outputs.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqOut_reg <= 5'h00;
		end else begin
			irqOut_reg <= {|irqMasked, irqMasked};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign awready        = awready_reg;
	assign wready         = wready_reg;
	assign bvalid         = bvalid_reg;
	assign bresp          = bresp_reg;
	assign arready        = arready_reg;
	assign rvalid         = rvalid_reg;
	assign rdata          = rdata_reg;
	assign rresp          = rresp_reg;
	assign serialTxOut    = serialTxOut_reg;
	assign bitClkOut      = bitClkOut_reg;
	assign requestToSendN = request_to_send_n_reg;
	assign terminalReadyN = terminal_ready_n_reg;
	assign modemStatusIrq = irqOut_reg[0];
	assign rxFifoIrq      = irqOut_reg[1];
	assign txFifoIrq      = irqOut_reg[2];
	assign rxTimeoutIrq   = irqOut_reg[3];
	assign combinedIrq    = irqOut_reg[4];

endmodule : uihm_core

// ### verification/uihm_core_props.sv
// Port checker for the serial port core, bound to its top module.
`timescale 1ns/1ps
module uihm_core_props (
	input wire logic        sys_clk, rst_b, awvalid, awready, wvalid, wready,
	input wire logic        bvalid, bready, arvalid, arready, rvalid, rready,
	input wire logic        modemStatusIrq, rxFifoIrq, rxTimeoutIrq, txFifoIrq, combinedIrq,
	input wire logic [1:0]  bresp, rresp,
	input wire logic [31:0] rdata
);
	// All checks share the bus clock; reset silences them.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// The combined line must follow the four masked sources exactly.
	irq_or_a: assert property (combinedIrq == (modemStatusIrq | rxFifoIrq | rxTimeoutIrq | txFifoIrq))
		else $error("combined interrupt differs from its sources");
	// Answers and their holding, tied to the handshakes that cause them.
	b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer missing");
	r_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped early");
	w_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	r_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	err_zero_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
		else $error("refused read returns data");
endmodule : uihm_core_props

bind uihm_core uihm_core_props props_i (.*);

// ### verification/uihm_peer.sv
// Remote serial peer: modem status lines and one externally clocked byte each way.
`timescale 1ns/1ps
module uihm_peer (
	input  wire logic       clkRun,
	input  wire logic [7:0] sendByte,
	input  wire logic       lineIn,
	input  wire logic [2:0] modemLvl,
	output logic            rxLine,
	output logic            clkLine,
	output logic [7:0]      seenByte,
	output logic [2:0]      modemN
);
	int k;

	// Outside a byte the line rests at mark and the clock stands still.
	initial begin
		rxLine   = 1'b1;
		clkLine  = 1'b0;
		seenByte = 8'h00;
	end

	// One byte per request, LSB first; data changes at the fall, both sides sample the rise.
	// The 10 ns offset keeps every change away from the bench clock edge.
	always @(posedge clkRun) begin
		#10;
		for (k = 0; k < 8; k++) begin
			rxLine = sendByte[k];
			#300 clkLine = 1'b1;
			seenByte = {lineIn, seenByte[7:1]};
			#340 clkLine = 1'b0;
		end
		rxLine = 1'b1;
	end

	// Modem status pins are active low copies of the requested levels.
	assign modemN = ~modemLvl;
endmodule : uihm_peer

// ### verification/testbench.sv
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
`include "uihm_consts.svh"
module testbench;
	logic        sys_clk = 1'b0, rst_b = 1'b0, phoneBellDetect = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  wstrb = 4'h0;
	logic [2:0]  modemLvl = 3'h0;
	logic [1:0]  bresp, rresp, r, b;
	logic        clkRun = 1'b0, ck = 1'b0;
	logic [7:0]  sendByte = 8'h00, seenByte, sh = 8'h00, m = 8'h35;
	logic        awready, wready, bvalid, arready, rvalid, serialRxIn, serialTxOut;
	logic        bitClkIn, bitClkOut, clearToSendN, carrierDetectN, dataSetReadyN;
	logic        requestToSendN, terminalReadyN;
	logic        modemStatusIrq, rxFifoIrq, rxTimeoutIrq, txFifoIrq, combinedIrq;
	int          n_mismatch = 0, samples_checked = 0, cyc = 0, i, nr = 0;

	uihm_core dut (.*);
	uihm_peer peer (.clkRun(clkRun), .sendByte(sendByte), .lineIn(serialTxOut),
		.modemLvl(modemLvl), .rxLine(serialRxIn), .clkLine(bitClkIn), .seenByte(seenByte),
		.modemN({clearToSendN, carrierDetectN, dataSetReadyN}));

	// Clock, and a cycle ceiling so a hung wait still ends in a verdict.
	initial forever #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// Bus write: release each channel when taken, answer accepted one cycle late.
	task wr(input logic [5:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			tick(1);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do tick(1); while (!bvalid);
		bready <= 1'b1;
		tick(1);
		b = bresp;
		bready <= 1'b0;
	endtask : wr

	// Bus read; the late ready lets the answer be seen standing.
	task rd(input logic [5:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do tick(1); while (!arready);
		arvalid <= 1'b0;
		do tick(1); while (!rvalid);
		rready <= 1'b1;
		tick(1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run

	// Main sequence: reset values, holding mode, loopback, buffers, modem.
	initial begin
		tick(8);
		rst_b <= 1'b1;
		tick(1);
		rd(`UIHM_OFF_CTRL);
		chk(d, 32'h0);
		rd(`UIHM_OFF_IRQ);
		chk(d, 32'h4);
		rd(6'h24);
		chk(r, 32'h2);
		wr(6'h24, 32'h0);
		chk(b, 32'h2);
		wr(`UIHM_OFF_LINE, 32'h0);
		chk(b, 32'h0);
		wr(`UIHM_OFF_CTRL, 32'h20);
		tick(2);
		chk(txFifoIrq, 32'h1);
		chk(combinedIrq, 32'h1);
		wr(`UIHM_OFF_DATA, 32'h41);
		tick(2);
		chk(txFifoIrq, 32'h0);
		wr(`UIHM_OFF_DIVISOR, 32'h0);
		wr(`UIHM_OFF_CTRL, 32'h91);
		repeat (400) if (!rxFifoIrq) tick(1);
		chk(rxFifoIrq, 32'h1);
		rd(`UIHM_OFF_DATA);
		chk(d, 32'h41);
		tick(2);
		chk(rxFifoIrq, 32'h0);
		wr(`UIHM_OFF_DATA, 32'h55);
		repeat (400) if (!rxFifoIrq) tick(1);
		wr(`UIHM_OFF_DATA, 32'hAA);
		tick(250);
		rd(`UIHM_OFF_STATUS);
		chk(d[2], 32'h1);
		wr(`UIHM_OFF_CTRL, 32'hC1);
		tick(2);
		chk(rxFifoIrq, 32'h0);
		repeat (700) if (!rxTimeoutIrq) tick(1);
		chk(rxTimeoutIrq, 32'h1);
		rd(`UIHM_OFF_DATA);
		chk(d, 32'h55);
		tick(2);
		chk(rxTimeoutIrq, 32'h0);
		wr(`UIHM_OFF_CTRL, 32'h30);
		wr(`UIHM_OFF_LINE, 32'h10);
		for (i = 1; i <= 9; i++) begin
			wr(`UIHM_OFF_DATA, i);
			tick(2);
			chk(txFifoIrq, i <= 8);
		end
		wr(`UIHM_OFF_CTRL, 32'hB1);
		tick(1700);
		for (i = 1; i <= 9; i++) begin
			tick(2);
			chk(rxFifoIrq, 10 - i >= 8);
			rd(`UIHM_OFF_DATA);
			chk(d, i);
		end
		wr(`UIHM_OFF_CTRL, 32'h08);
		modemLvl <= 3'h5;
		tick(6);
		chk(modemStatusIrq, 32'h1);
		wr(`UIHM_OFF_IRQ, 32'h0);
		tick(2);
		chk(modemStatusIrq, 32'h0);
		wr(`UIHM_OFF_MCTL, 32'h3);
		tick(2);
		chk({requestToSendN, terminalReadyN}, 32'h0);
		// Frame link: eight bits, no parity; link enables set before the port, cleared after.
		wr(`UIHM_OFF_LINE, 32'h10);
		wr(`UIHM_OFF_FLINK, 32'h65);
		wr(`UIHM_OFF_CTRL, 32'h01);
		wr(`UIHM_OFF_DATA, 32'hA5);
		// Own clock: sample the line at each clock rise, count the rises.
		repeat (200) begin
			tick(1);
			if (bitClkOut && !ck) begin
				sh = {serialTxOut, sh[7:1]};
				nr++;
			end
			ck = bitClkOut;
		end
		chk(sh, 32'hA5);
		chk(nr, 32'h8);
		wr(`UIHM_OFF_CTRL, 32'h00);
		wr(`UIHM_OFF_FLINK, 32'h0D);
		wr(`UIHM_OFF_DATA, 32'h35);
		wr(`UIHM_OFF_CTRL, 32'h01);
		// Manchester: the first bit is a one, so its low first half marks the start.
		repeat (100) if (serialTxOut) tick(1);
		for (i = 0; i < 8; i++) begin
			tick(4);
			chk(serialTxOut, !m[i]);
			tick(8);
			chk(serialTxOut, m[i]);
			tick(4);
		end
		wr(`UIHM_OFF_CTRL, 32'h00);
		wr(`UIHM_OFF_FLINK, 32'hC7);
		wr(`UIHM_OFF_CTRL, 32'h01);
		wr(`UIHM_OFF_DATA, 32'h96);
		sendByte <= 8'h3C;
		clkRun <= 1'b1;
		tick(150);
		chk(seenByte, 32'h96);
		rd(`UIHM_OFF_DATA);
		chk(d, 32'h3C);
		wr(`UIHM_OFF_CTRL, 32'h00);
		wr(`UIHM_OFF_FLINK, 32'h00);
		complete_run();
	end
endmodule : testbench
